//--- inc/hall_sweep_regs.vh
// constants for the hall threshold sweep estimator and its i2c dac writer
// assumes a 25 mhz system clock and an 8-bit dac spanning 0 to 1.82 v
`ifndef HALL_SWEEP_REGS_VH
`define HALL_SWEEP_REGS_VH

// clock rate in khz
`define CLK_KHZ 25000
// sensor magnetic sampling period; the settle wait must exceed it
`define SAMPLE_PERIOD_MS 50
// settle time spent on each dac code
`define SETTLE_MS 100
// settle cycles derived from time and rate
`define SETTLE_CYCLES (`SETTLE_MS * `CLK_KHZ)

// dac resolution and full scale
`define DAC_BITS 8
`define DAC_FS_MV 1820
// adjust pin operating range
`define ADJ_TOP_MV 1200
`define ADJ_FLOOR_MV 160
// code that places the top of the range on the adjust pin (rounded down)
`define TOP_CODE ((`ADJ_TOP_MV << `DAC_BITS) / `DAC_FS_MV)
// highest code still at or below the floor voltage
`define FLOOR_CODE ((`ADJ_FLOOR_MV << `DAC_BITS) / `DAC_FS_MV)
// flux in units of 0.01 mt per mv: 0.0125 * 100 = 5 / 4
`define FLUX_NUM 5
`define FLUX_DEN 4

// i2c bus rate and quarter bit time, rounded up so the bus never runs fast
`define I2C_KHZ 100
`define I2C_QTR ((`CLK_KHZ + 4 * `I2C_KHZ - 1) / (4 * `I2C_KHZ))
// number of dacs that may share one bus
`define DAC_SLOTS 4
// dac bus address of slot 0; slots follow consecutively
`define DAC_ADDR_BASE 7'h48
// dac data register, left shift of the code inside its 16-bit word
`define DAC_DATA_REG 8'h21
`define DAC_DATA_SHIFT 4
// dac register and word that commit the output setting to nonvolatile memory
`define DAC_NVM_REG 8'h1f
`define DAC_NVM_WORD 16'h0010

`endif

//--- core/dac_i2c_writer.v
// i2c master that writes one 16-bit word to one register of one dac
// assumes open-drain scl/sda with external pull-ups; honours clock stretching in data and acknowledge bits, not before the stop
`timescale 1ns/1ps
`include "hall_sweep_regs.vh"

module dac_i2c_writer #(
    parameter QTR = `I2C_QTR
) (
    input wire ref_clk,
    input wire resetn,
    input wire go,
    input wire [6:0] dev_addr,
    input wire [7:0] reg_addr,
    input wire [15:0] word,
    output wire busy,
    output reg done,
    output reg nack,
    input wire scl_i,
    output reg scl_oe,
    input wire sda_i,
    output reg sda_oe
);

    // one-hot frame states
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_START = 4'b0010;
    localparam [3:0] S_BIT = 4'b0100;
    localparam [3:0] S_STOP = 4'b1000;

    reg [3:0] state_q; // frame state
    reg [6:0] qcnt_q; // quarter bit timer
    reg [1:0] ph_q; // quarter within the bit
    reg [3:0] bit_q; // 0..7 data, 8 acknowledge
    reg [2:0] byte_q; // 0 address, 1 register, 2 high, 3 low
    reg [31:0] sh_q; // bytes still to send, msb first
    reg scl_m_q, scl_s_q, sda_m_q, sda_s_q; // pin synchronisers
    wire stretch; // slave holds scl low while we released it
    wire tick; // end of a quarter bit

    assign busy = (state_q != S_IDLE);
    assign stretch = (state_q == S_BIT) && (ph_q == 2'd2) && !scl_s_q;
    assign tick = (qcnt_q == QTR[6:0] - 7'd1) && !stretch;

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for the bus pins
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame sequencer: start, four bytes with acknowledge, stop
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= S_IDLE;
            qcnt_q <= 7'h00;
            ph_q <= 2'd0;
            bit_q <= 4'h0;
            byte_q <= 3'd0;
            sh_q <= 32'h00000000;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            nack <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            // timer holds its count while the slave stretches
            if (state_q == S_IDLE || tick)
                qcnt_q <= 7'h00;
            else if (!stretch)
                qcnt_q <= qcnt_q + 7'd1;
            case (state_q)
                S_IDLE: begin
                    ph_q <= 2'd0;
                    if (go) begin // [R12]
                        sh_q <= {dev_addr, 1'b0, reg_addr, word};
                        nack <= 1'b0;
                        bit_q <= 4'h0;
                        byte_q <= 3'd0;
                        state_q <= S_START;
                    end
                end
                S_START: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    if (ph_q == 2'd1)
                        sda_oe <= 1'b1; // sda falls with scl high
                    if (ph_q == 2'd2) begin
                        scl_oe <= 1'b1;
                        ph_q <= 2'd0;
                        state_q <= S_BIT;
                    end
                end
                S_BIT: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    case (ph_q)
                        2'd0: sda_oe <= (bit_q == 4'd8) ? 1'b0 : !sh_q[31];
                        2'd1: scl_oe <= 1'b0;
                        2'd2: begin
                            if (bit_q == 4'd8)
                                nack <= nack | sda_s_q; // any missing ack sticks
                        end
                        default: begin
                            scl_oe <= 1'b1;
                            if (bit_q == 4'd8) begin
                                bit_q <= 4'h0;
                                byte_q <= byte_q + 3'd1;
                                if (byte_q == 3'd3)
                                    state_q <= S_STOP;
                            end else begin
                                bit_q <= bit_q + 4'd1;
                                sh_q <= {sh_q[30:0], 1'b0};
                            end
                        end
                    endcase
                end
                S_STOP: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    case (ph_q)
                        2'd0: sda_oe <= 1'b1;
                        2'd1: scl_oe <= 1'b0;
                        2'd2: sda_oe <= 1'b0; // sda rises with scl high
                        default: begin
                            done <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    endcase
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

endmodule // dac_i2c_writer

//--- core/hall_threshold_sweep_estimator.v
// controller that estimates flux density at a threshold-adjustable hall switch
// by sweeping a dac on its threshold_adjust_pin down from the top of the range;
// optionally commits the found code to the dac nonvolatile memory.
// assumes the switch output arrives asynchronously and the dac sits on i2c.
`timescale 1ns/1ps
`include "hall_sweep_regs.vh"

// Behaviour
// [R1] start each estimate at the 1.2 v code
// [R2] 1.2 v gives 15/14 mt, release min 11.65
// [R3] output low at start: report too large
// [R4] each step lowers the dac one code
// [R5] settle over 50 ms, 100 ms default
// [R6] output low: flux mt = mv times 0.0125
// [R7] still high, next above 0.16 v: repeat
// [R8] still high, next at floor: below 2 mt
// [R9] sweep only codes within 0.16..1.2 v
// [R10] calibration stores the found code in nvm
// [R11] dac restores stored voltage after power-on
// [R12] program the dac over i2c, four per bus
// [R13] hold code, done and range flags until restart
module hall_threshold_sweep_estimator #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter I2C_QTR = `I2C_QTR
) (
    input wire ref_clk,
    input wire resetn,
    input wire start,
    input wire calibrate,
    input wire [1:0] dac_sel,
    input wire switch_out,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe,
    output wire busy,
    output reg done,
    output reg too_large,
    output reg too_small,
    output reg bus_error,
    output reg [7:0] final_code,
    output reg [10:0] adj_mv,
    output reg [11:0] flux_centi_mt
);

    ////////////////////////////////////////////////////////////////////
    // how an estimate runs
    //
    // start clears the flags, latches the
    // calibrate choice, loads the top code.
    // each code goes out as one i2c frame:
    // address, data register, then the code
    // shifted up in a 16-bit word.
    //
    // settle then runs its whole count.
    // the switch takes a new threshold only
    // at its own sampling instants, so an
    // early read judges the old code.
    // the default is twice that period, for
    // slow parts; below one period the
    // estimate is wrong.
    //
    // the check state reads the switch:
    // - low at the top code: too large.
    // - low later: this code is the point;
    //   voltage and flux are latched.
    // - high, room below: one code lower.
    // - high, next at the floor: too small.
    //
    // a nack on a code write aborts, since
    // the pin voltage is then unknown.
    // a nack on the commit still reports
    // the estimate; bus_error warns that
    // the stored code may be stale.
    //
    // a frame is about 37 bit times, well
    // under a millisecond, against 100 ms
    // of settle, so frames and settle are
    // not overlapped: it would save little.
    //
    // results change only at a start and in the
    // write, check, commit and finish states,
    // and stand until the next accepted start.
    // a start while busy is dropped silently.
    //
    // flux and voltage round down, so the
    // readout shows no more precision than
    // one dac step gives.
    //
    // dac_sel is read directly and must
    // hold while busy. a single read of the
    // switch is trusted; a marginal field
    // is not sampled twice.
    //
    // reset drops a sweep in progress and
    // releases the bus; the dac keeps its
    // last code, or its stored one if it
    // was reset as well.

    ////////////////////////////////////////////////////////////////////
    // constants

    localparam integer TOP_I = `TOP_CODE;
    localparam integer FLOOR_I = `FLOOR_CODE;
    localparam [7:0] TOP_CODE = TOP_I[7:0]; // [R1]
    localparam [7:0] FLOOR_CODE = FLOOR_I[7:0]; // [R9]
    localparam integer SETTLE_I = SETTLE_CYCLES - 1;
    localparam [21:0] SETTLE_LAST = SETTLE_I[21:0];
    // scaling constants at the width of the products they feed
    localparam integer FS_I = `DAC_FS_MV;
    localparam [19:0] FS_MV = FS_I[19:0];
    localparam integer FN_I = `FLUX_NUM;
    localparam [13:0] FLUX_K = FN_I[13:0];

    // one-hot sweep states
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_WRITE = 6'b000010;
    localparam [5:0] S_SETTLE = 6'b000100;
    localparam [5:0] S_CHECK = 6'b001000;
    localparam [5:0] S_NVM = 6'b010000;
    localparam [5:0] S_FINISH = 6'b100000;

    ////////////////////////////////////////////////////////////////////
    // dac code to millivolts on the adjust pin
    function [10:0] mv_of;
        input [7:0] code;
        reg [19:0] p;
        begin
            p = {12'h000, code} * FS_MV;
            mv_of = p[18:8];
        end
    endfunction

    // millivolts to flux density in hundredths of a millitesla
    function [11:0] flux_of;
        input [10:0] mv;
        reg [13:0] p;
        begin
            p = {3'b000, mv} * FLUX_K;
            flux_of = p[13:2];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    reg [5:0] state_q; // sweep state
    reg [7:0] code_q; // code now on the dac
    reg first_q; // first check, at the top code
    reg calib_q; // calibration run latched at start
    reg sent_q; // i2c write already launched in this state
    reg [21:0] wait_q; // settle counter
    reg sw_m_q, sw_s_q; // switch output synchroniser
    wire i2c_go; // launch one i2c write
    wire i2c_busy;
    wire i2c_done;
    wire i2c_nack;
    wire [7:0] i2c_reg;
    wire [15:0] i2c_word;
    wire [6:0] dev_addr;
    wire [15:0] code_word;

    assign busy = (state_q != S_IDLE);
    // the two bus pins are open drain: only ever pulled low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    // up to four dacs share the bus; the select picks the address
    assign dev_addr = `DAC_ADDR_BASE + {5'b00000, dac_sel}; // [R12]
    assign code_word = {8'h00, code_q} << `DAC_DATA_SHIFT;
    // handshake launch, one cycle while the writer is idle;
    // sent_q stops a second launch in the
    // cycle the writer drops back to idle
    assign i2c_go = (state_q == S_WRITE || state_q == S_NVM) && !sent_q && !i2c_busy;
    assign i2c_reg = (state_q == S_NVM) ? `DAC_NVM_REG : `DAC_DATA_REG;
    assign i2c_word = (state_q == S_NVM) ? `DAC_NVM_WORD : code_word;

    ////////////////////////////////////////////////////////////////////
    // switch output crosses in through two flops;
    // reset high so no false low is read
    // before the first real sample
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sw_m_q <= 1'b1;
            sw_s_q <= 1'b1;
        end else begin
            sw_m_q <= switch_out;
            sw_s_q <= sw_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sweep sequencer
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= S_IDLE;
            code_q <= 8'h00;
            first_q <= 1'b0;
            calib_q <= 1'b0;
            sent_q <= 1'b0;
            wait_q <= 22'h000000;
            done <= 1'b0;
            too_large <= 1'b0;
            too_small <= 1'b0;
            bus_error <= 1'b0;
            final_code <= 8'h00;
            adj_mv <= 11'h000;
            flux_centi_mt <= 12'h000;
        end else begin
            if (i2c_go)
                sent_q <= 1'b1;
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        // results stand until this point [R13]
                        done <= 1'b0;
                        too_large <= 1'b0;
                        too_small <= 1'b0;
                        bus_error <= 1'b0;
                        calib_q <= calibrate;
                        code_q <= TOP_CODE; // [R1]
                        first_q <= 1'b1;
                        sent_q <= 1'b0;
                        state_q <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    // dac code goes out over i2c, then the switch settles
                    if (i2c_done) begin
                        sent_q <= 1'b0;
                        wait_q <= 22'h000000;
                        if (i2c_nack) begin
                            bus_error <= 1'b1;
                            state_q <= S_FINISH;
                        end else
                            state_q <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    // wait well past one sampling period so the new
                    // threshold is in force before the output is read
                    if (wait_q == SETTLE_LAST) // [R5]
                        state_q <= S_CHECK;
                    else
                        wait_q <= wait_q + 22'd1;
                end
                S_CHECK: begin
                    first_q <= 1'b0;
                    final_code <= code_q;
                    adj_mv <= mv_of(code_q);
                    if (!sw_s_q) begin
                        if (first_q) begin
                            // field above the release threshold at the top [R3]
                            too_large <= 1'b1;
                            state_q <= S_FINISH;
                        end else begin
                            // switched: convert the present voltage [R6]
                            flux_centi_mt <= flux_of(mv_of(code_q));
                            state_q <= calib_q ? S_NVM : S_FINISH; // [R10]
                        end
                    end else if (code_q - 8'd1 > FLOOR_CODE) begin // [R7] [R9]
                        code_q <= code_q - 8'd1; // [R4]
                        state_q <= S_WRITE;
                    end else begin
                        too_small <= 1'b1; // [R8]
                        state_q <= S_FINISH;
                    end
                end
                S_NVM: begin
                    // the dac restores this code on its own after power-on,
                    // so no controller is needed afterwards [R11]
                    if (i2c_done) begin
                        sent_q <= 1'b0;
                        bus_error <= i2c_nack;
                        state_q <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    done <= 1'b1; // [R13]
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // i2c writer for the dac
    dac_i2c_writer #(
        .QTR(I2C_QTR)
    ) u_writer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .go(i2c_go),
        .dev_addr(dev_addr),
        .reg_addr(i2c_reg),
        .word(i2c_word),
        .busy(i2c_busy),
        .done(i2c_done),
        .nack(i2c_nack),
        .scl_i(scl_i),
        .scl_oe(scl_oe),
        .sda_i(sda_i),
        .sda_oe(sda_oe)
    );

endmodule // hall_threshold_sweep_estimator

//--- verification/hall_sweep_monitor.sv
// checker for the hall threshold sweep estimator, bound to its top ports
// assumes one clock domain and the 8-bit dac code figures of the design
`timescale 1ns/1ps
module hall_sweep_monitor #(
    parameter SETTLE_CYCLES = 20,
    parameter I2C_QTR = 2
) (
    input wire ref_clk,
    input wire resetn,
    input wire start,
    input wire scl_o,
    input wire scl_oe,
    input wire sda_o,
    input wire sda_oe,
    input wire busy,
    input wire done,
    input wire too_large,
    input wire too_small,
    input wire bus_error,
    input wire [7:0] final_code,
    input wire [10:0] adj_mv,
    input wire [11:0] flux_centi_mt
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // expected scalings, widened so the products cannot wrap
    wire [18:0] mv_exp = ({11'h000, final_code} * 19'd1820) >> 8;
    wire [13:0] flux_exp = ({3'h0, adj_mv} * 14'd5) >> 2;
    sequence s_accept;
        start && !busy;
    endsequence
    sequence s_cleared;
        busy && !done && !too_large && !too_small && !bus_error;
    endsequence
    sequence s_idle_done;
        !busy && done && !start;
    endsequence
    a_start_clears: assert property (s_accept |=> s_cleared)
        else $error("results not cleared by an accepted start");
    a_start_frame: assert property (s_accept |-> ##[1:300] sda_oe)
        else $error("no bus frame after start");
    a_results_hold: assert property (s_idle_done |=> done && $stable(final_code) && $stable(flux_centi_mt))
        else $error("results moved while idle");
    a_large_top: assert property (done && too_large |-> final_code == 8'ha8)
        else $error("too large not at top code");
    a_small_floor: assert property (done && too_small |-> final_code == 8'h17)
        else $error("too small not at last code above floor");
    a_code_range: assert property (done && !bus_error |-> final_code <= 8'ha8 && final_code >= 8'h17)
        else $error("final code outside adjust range");
    a_mv_scale: assert property (done && !bus_error |-> adj_mv == mv_exp[10:0])
        else $error("voltage does not match code");
    a_flux_scale: assert property (done && !too_large && !too_small && !bus_error
        |-> flux_centi_mt == flux_exp[11:0])
        else $error("flux does not match voltage");
    a_finish_flag: assert property ($fell(busy) |-> done || bus_error)
        else $error("busy fell with no result");
    a_idle_bus: assert property (!busy |-> !scl_oe && !sda_oe && !scl_o && !sda_o)
        else $error("bus held while idle");
endmodule // hall_sweep_monitor

bind hall_threshold_sweep_estimator hall_sweep_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES), .I2C_QTR(I2C_QTR)) mon (
    .ref_clk(ref_clk), .resetn(resetn), .start(start), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
    .sda_oe(sda_oe), .busy(busy), .done(done), .too_large(too_large), .too_small(too_small),
    .bus_error(bus_error), .final_code(final_code), .adj_mv(adj_mv), .flux_centi_mt(flux_centi_mt));

//--- verification/hall_dac_switch_model.sv
// model of an i2c dac with nonvolatile memory driving a hall switch adjust pin
// assumes pull-ups on scl/sda; the switch samples its field every SAMPLE cycles
`timescale 1ns/1ps
module hall_dac_switch_model #(
    parameter logic [6:0] DEV_ADDR = 7'h48,
    parameter int SAMPLE = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic [11:0] field_centi,
    output logic sda_pull,
    output logic switch_out,
    output logic [7:0] dac_code,
    output logic [7:0] nvm_code
);
    logic [7:0] sh, regb, hib; // shift register and captured bytes
    logic sel; // addressed in this frame
    int bitn, byten, tick;
    int thr; // operate threshold in 0.01 mt for the current code
    assign thr = ((int'(dac_code) * 1820) >> 8) * 5 / 4;
    initial begin
        sda_pull = 0; switch_out = 1; dac_code = 0; nvm_code = 0; sel = 0; bitn = 0; byten = 0; tick = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // start condition restarts byte counting
    always @(negedge sda) if (scl === 1'b1) begin
        bitn = 0; byten = 0; sel = 0;
    end
    always @(posedge scl) if (bitn < 8) begin
        sh = {sh[6:0], sda}; bitn = bitn + 1;
    end
    // ack only our own address; a foreign address is left unanswered
    always @(negedge scl) begin
        if (sda_pull) begin
            sda_pull = 0; bitn = 0; byten = byten + 1;
        end else if (bitn == 8) begin
            if (byten == 0) sel = (sh[7:1] == DEV_ADDR) && !sh[0];
            else if (byten == 1) regb = sh;
            else if (byten == 2) hib = sh;
            else if (sel && byten == 3) begin
                if (regb == 8'h21) dac_code = {hib[3:0], sh[7:4]};
                if (regb == 8'h1f && {hib, sh} == 16'h0010) nvm_code = dac_code;
            end
            sda_pull = sel;
        end
    end
    // a reset event reloads the stored code
    always @(negedge resetn) dac_code = nvm_code;
    // the switch only sees a new threshold at its own sampling instants
    always @(posedge ref_clk) begin
        tick <= (tick == SAMPLE - 1) ? 0 : tick + 1;
        if (tick == 0) switch_out <= (field_centi >= thr) ? 1'b0 : 1'b1;
    end
endmodule // hall_dac_switch_model

//--- verification/hall_threshold_sweep_estimator_tb_top.sv
// testbench: sweeps, out-of-range ends, calibration, refused start, bus nack
// assumes the model at dac slot 0 and short settle and bit times
`timescale 1ns/1ps
module hall_threshold_sweep_estimator_tb_top;
    logic ref_clk, resetn, start, calibrate, switch_out, sda_pull;
    logic [1:0] dac_sel;
    logic [11:0] field;
    wire scl_oe, sda_oe, busy, done, too_large, too_small, bus_error;
    wire [7:0] final_code, dac_code, nvm_code;
    wire [10:0] adj_mv;
    wire [11:0] flux_centi_mt;
    wire scl = scl_oe ? 1'b0 : 1'b1; // pull-ups on both wires
    wire sda = (sda_oe || sda_pull) ? 1'b0 : 1'b1;
    int miscompares = 0, num_checks = 0;
    hall_threshold_sweep_estimator #(.SETTLE_CYCLES(20), .I2C_QTR(2)) dut (
        .ref_clk(ref_clk), .resetn(resetn), .start(start), .calibrate(calibrate), .dac_sel(dac_sel),
        .switch_out(switch_out), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
        .busy(busy), .done(done), .too_large(too_large), .too_small(too_small), .bus_error(bus_error),
        .final_code(final_code), .adj_mv(adj_mv), .flux_centi_mt(flux_centi_mt));
    hall_dac_switch_model part (.ref_clk(ref_clk), .resetn(resetn), .scl(scl), .sda(sda), .field_centi(field),
        .sda_pull(sda_pull), .switch_out(switch_out), .dac_code(dac_code), .nvm_code(nvm_code));
    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic int thr_of(input int c);
        return ((c * 1820) >> 8) * 5 / 4;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one estimate; a second start at cycle poke must be ignored while busy
    task automatic run(input logic cal, input logic [1:0] sel, input logic [11:0] fld, input int poke);
        int n;
        @(posedge ref_clk);
        field <= fld; calibrate <= cal; dac_sel <= sel; start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        for (n = 0; n < 80000; n++) begin
            @(posedge ref_clk);
            start <= (n == poke);
            #1;
            if (busy === 1'b0) break;
        end
        if (n >= 80000) begin
            miscompares++;
            test_done();
        end
        @(negedge ref_clk);
    endtask
    task automatic sc_sweep(input logic [11:0] fld, input logic cal, input int poke);
        int c;
        c = 168;
        while (fld < thr_of(c) && c > 23) c--;
        run(cal, 2'b00, fld, poke);
        check(done, 16'h1);
        check(too_large, fld >= thr_of(168));
        check(too_small, fld < thr_of(c));
        check(final_code, 16'(c));
        check(dac_code, 16'(c));
        check(bus_error, 16'h0);
        if (c < 168 && fld >= thr_of(c)) begin
            check(adj_mv, 16'((c * 1820) >> 8));
            check(flux_centi_mt, 16'(thr_of(c)));
        end
        if (cal) check(nvm_code, 16'(c));
    endtask
    task automatic sc_reset(input logic [7:0] exp_dac);
        resetn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        check(dac_code, exp_dac);
        check({done, busy, too_large, too_small, bus_error, scl_oe, sda_oe}, 16'h0);
    endtask
    task automatic sc_nack;
        run(1'b0, 2'b01, 12'd500, -1);
        check(bus_error, 16'h1);
        check(too_large | too_small, 16'h0);
    endtask
    initial begin
        resetn = 1; start = 0; calibrate = 0; dac_sel = 0; field = 0;
        sc_reset(8'h00);
        sc_sweep(12'd878, 1'b0, 30); // mid range, refused second start
        sc_sweep(12'd1491, 1'b0, -1); // switches one step below the top
        sc_sweep(12'd1500, 1'b0, -1); // too large at the top code
        sc_sweep(12'd100, 1'b0, -1); // too small, full sweep to the floor
        sc_sweep(12'd1400, 1'b1, -1); // calibration commit
        sc_reset(8'h9d); // code 157 found for a field of 14.00 mt
        sc_nack;
        test_done();
    end
endmodule // hall_threshold_sweep_estimator_tb_top
